//--- kpi_keypad_pin_interrupt.sv
// port-zero pin change interrupt unit: eight channels, per-channel trigger type,
// sticky edge flags, level-following low flags, one combined request and a wake request
// assumes asynchronous pins on port_zero and a cpu that reports idle and power-down
// as levels on aclk; one machine cycle is one aclk period
`include "kpi_map.svh"

module kpi_keypad_pin_interrupt
	import kpi_pkg::*;
(
	// clock and reset
	input  logic               aclk,
	input  logic               aresetn,
	// axi4-lite write address
	input  kpi_addr_t          s_axi_awaddr,
	input  logic               s_axi_awvalid,
	output logic               s_axi_awready,
	// axi4-lite write data
	input  logic [`KPI_DW-1:0] s_axi_wdata,
	input  logic [`KPI_SW-1:0] s_axi_wstrb,
	input  logic               s_axi_wvalid,
	output logic               s_axi_wready,
	// axi4-lite write response
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  logic               s_axi_bready,
	// axi4-lite read address
	input  kpi_addr_t          s_axi_araddr,
	input  logic               s_axi_arvalid,
	output logic               s_axi_arready,
	// axi4-lite read data
	output logic [`KPI_DW-1:0] s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  logic               s_axi_rready,
	// keypad pins
	input  logic [7:0]         port_zero,
	// processor power state
	input  logic               cpu_idle,
	input  logic               cpu_power_down,
	// requests
	output logic               keypad_irq,
	output logic               wake_req
);

	kpi_reg_if rif ();

	// register file
	logic [7:0] en_q;
	logic [7:0] flag_q;
	logic [7:0] sel_lo_q;
	logic [7:0] sel_hi_q;
	logic [1:0] ctrl_q;

	// detection pipeline
	logic [7:0] pin_lvl;
	logic [7:0] prev_q;
	logic [7:0] hit_q;
	logic [7:0] low_q;
	logic       irq_q;
	logic       wake_q;

	// decode and next values
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic       wr_enable;
	logic       wr_flags;
	logic       wr_sel_lo;
	logic       wr_sel_hi;
	logic       wr_ctrl;
	logic [7:0] en_d;
	logic [7:0] sel_lo_d;
	logic [7:0] sel_hi_d;
	logic [1:0] ctrl_d;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] level_ch;
	logic [7:0] hit_now;
	logic [7:0] low_now;
	logic [7:0] flag_sw;
	logic [7:0] flag_d;
	logic       any_flag;
	logic       irq_d;
	logic       wake_d;

	kpi_pin_sync u_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  (port_zero),
		.level_q (pin_lvl)
	);

	kpi_axil_slave u_bus
	(
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rif           (rif)
	);

	// write decode
	assign wr_idx    = kpi_reg_idx(rif.wr_addr);
	assign wr_enable = rif.wr_stb && (wr_idx == `KPI_IDX_ENABLE);
	assign wr_flags  = rif.wr_stb && (wr_idx == `KPI_IDX_FLAGS);
	assign wr_sel_lo = rif.wr_stb && (wr_idx == `KPI_IDX_SEL_LO);
	assign wr_sel_hi = rif.wr_stb && (wr_idx == `KPI_IDX_SEL_HI);
	assign wr_ctrl   = rif.wr_stb && (wr_idx == `KPI_IDX_CTRL);

	assign en_d     = wr_enable ? rif.wr_data : en_q;
	assign sel_lo_d = wr_sel_lo ? rif.wr_data : sel_lo_q;
	assign sel_hi_d = wr_sel_hi ? rif.wr_data : sel_hi_q;
	assign ctrl_d   = wr_ctrl ? rif.wr_data[1:0] : ctrl_q;

	// settled level against the previous settled level
	assign rise = pin_lvl & ~prev_q;
	assign fall = ~pin_lvl & prev_q;

	// both select bits set means low-level mode
	assign level_ch = sel_hi_q & sel_lo_q;

	genvar ch;
	for (ch = 0; ch < 8; ch++)
	begin : g_chan
		// channel ch reads bit ch of each select register
		assign hit_now[ch] = en_q[ch]
			& kpi_edge_hit(kpi_trig_t'({sel_hi_q[ch], sel_lo_q[ch]}), rise[ch], fall[ch]);
	end

	assign low_now = en_q & level_ch & ~pin_lvl;

	// software may write edge flags; hardware set wins over a clear in the same cycle
	assign flag_sw = wr_flags ? rif.wr_data : flag_q;
	assign flag_d  = (~level_ch & (flag_sw | hit_q)) | (level_ch & low_q);

	assign any_flag = |(flag_q & en_q);
	assign irq_d    = ctrl_q[`KPI_CTRL_IRQ_EN] & any_flag;
	assign wake_d   = ctrl_q[`KPI_CTRL_WAKE_EN] & any_flag & (cpu_idle | cpu_power_down);

	// read mux; pin levels let the handler find the pressed key
	assign rd_idx      = kpi_reg_idx(rif.rd_addr);
	assign rif.rd_data = (rd_idx == `KPI_IDX_ENABLE) ? en_q :
		(rd_idx == `KPI_IDX_FLAGS)  ? flag_q :
		(rd_idx == `KPI_IDX_SEL_LO) ? sel_lo_q :
		(rd_idx == `KPI_IDX_SEL_HI) ? sel_hi_q :
		(rd_idx == `KPI_IDX_CTRL)   ? {`KPI_CTRL_PAD, ctrl_q} :
		(rd_idx == `KPI_IDX_PINS)   ? pin_lvl : `KPI_RST_BYTE;

	assign keypad_irq = irq_q;
	assign wake_req   = wake_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			en_q     <= `KPI_RST_BYTE;
			flag_q   <= `KPI_RST_BYTE;
			sel_lo_q <= `KPI_RST_BYTE;
			sel_hi_q <= `KPI_RST_BYTE;
			ctrl_q   <= `KPI_RST_CTRL;
		end
		else
		begin
			en_q     <= en_d;
			flag_q   <= flag_d;
			sel_lo_q <= sel_lo_d;
			sel_hi_q <= sel_hi_d;
			ctrl_q   <= ctrl_d;
		end
	end

	// one stage here plus the flag register gives the two-cycle delay
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_q <= `KPI_PIN_IDLE;
			hit_q  <= `KPI_RST_BYTE;
			low_q  <= `KPI_RST_BYTE;
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			prev_q <= pin_lvl;
			hit_q  <= hit_now;
			low_q  <= low_now;
			irq_q  <= irq_d;
			wake_q <= wake_d;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking

	default disable iff (!aresetn);

	// a detected edge shows in the flag exactly two cycles later
	a_edge_flag_delay: assert property (
		(hit_now != `KPI_RST_BYTE) && !$past(wr_flags, 1) |->
		##2 ((flag_q & $past(hit_now, 2) & ~$past(level_ch, 1)) == ($past(hit_now, 2) & ~$past(level_ch, 1))))
	else $error("edge flag not set two cycles after detection");

	// the delay stage only carries channels that were enabled
	a_enable_gate: assert property (
		(hit_q & ~$past(en_q, 1)) == `KPI_RST_BYTE)
	else $error("disabled channel produced a trigger");

	// an edge-mode flag rises only from a detection or a software write
	a_edge_set_cause: assert property (
		!$past(wr_flags, 1) |->
		((flag_q & ~$past(flag_q, 1) & ~$past(level_ch, 1) & ~$past(hit_q, 1)) == `KPI_RST_BYTE))
	else $error("edge flag set without a cause");

	// an edge-mode flag stays set until software writes the flag register
	a_edge_sticky: assert property (
		!$past(wr_flags, 1) |->
		(($past(flag_q, 1) & ~$past(level_ch, 1) & ~level_ch & ~flag_q) == `KPI_RST_BYTE))
	else $error("edge flag dropped without a software clear");

	// a low-level flag mirrors the inverted pin, enabled or cleared
	a_level_follow: assert property (
		((flag_q ^ (~$past(pin_lvl, 2) & $past(en_q, 2))) & $past(level_ch, 2) & $past(level_ch, 1)
		& $past(level_ch & en_q, 1) & $past(en_q, 2) & level_ch) == `KPI_RST_BYTE)
	else $error("low-level flag does not follow the pin");

	// a write cannot move a low-level flag away from its pin
	a_level_write: assert property (
		wr_flags && (level_ch != `KPI_RST_BYTE) && !wr_sel_lo && !wr_sel_hi |=>
		((flag_q & level_ch) == ($past(low_q, 1) & level_ch)))
	else $error("software write reached a low-level flag");

	// decoding of the select pair per channel
	a_trig_decode: assert property (
		hit_now == (en_q & ((fall & ~sel_hi_q & ~sel_lo_q) | (rise & ~sel_hi_q & sel_lo_q)
		| ((rise | fall) & sel_hi_q & ~sel_lo_q))))
	else $error("trigger select decode wrong");

	// any enabled flag raises the single request when allowed
	a_irq_raise: assert property (
		any_flag && ctrl_q[`KPI_CTRL_IRQ_EN] |=> keypad_irq)
	else $error("combined request missing");

	// no enabled flag, no request
	a_irq_quiet: assert property (
		!any_flag |=> !keypad_irq)
	else $error("request without an enabled flag");

	// wake request from idle or power-down
	a_wake_power: assert property (
		any_flag && ctrl_q[`KPI_CTRL_WAKE_EN] && (cpu_idle || cpu_power_down) |=> wake_req)
	else $error("wake request missing");

	// reset clears the enable, flag and select registers and the combined request
	a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (en_q == `KPI_RST_BYTE) && (flag_q == `KPI_RST_BYTE)
		&& (sel_lo_q == `KPI_RST_BYTE) && (sel_hi_q == `KPI_RST_BYTE) && !keypad_irq)
	else $error("registers not cleared by reset");

	// reset also clears the delay stages and the wake request and sets the previous sample to the idle level
	a_reset_pipe: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (hit_q == `KPI_RST_BYTE) && (low_q == `KPI_RST_BYTE)
		&& !wake_req && (prev_q == `KPI_PIN_IDLE))
	else $error("detection pipeline not cleared by reset");

	// the previous sample is the settled level one cycle back
	a_prev_track: assert property (
		prev_q == $past(pin_lvl, 1))
	else $error("previous pin sample lost");

	// edges come only from pins whose settled level moved
	a_edge_source: assert property (
		(hit_now & ~(pin_lvl ^ prev_q)) == `KPI_RST_BYTE)
	else $error("edge reported on a steady pin");

	// a detection enters the delay stage one cycle later
	a_hit_stage: assert property (
		hit_q == $past(hit_now, 1))
	else $error("delay stage lost a detection");

	// a written edge flag takes the written value unless a detection sets it
	a_edge_store: assert property (
		wr_flags |=> (((flag_q ^ $past(rif.wr_data, 1)) & ~$past(level_ch, 1)
		& ~$past(hit_q, 1)) == `KPI_RST_BYTE))
	else $error("edge flag write not stored");

	// a hardware set beats a software clear in the same cycle
	a_set_wins: assert property (
		wr_flags |=> (($past(hit_q, 1) & ~$past(level_ch, 1) & ~flag_q) == `KPI_RST_BYTE))
	else $error("software clear beat a hardware set");

	// a disabled low-level channel keeps its flag clear
	a_level_disabled: assert property (
		(flag_q & $past(level_ch, 1) & ~$past(en_q, 2)) == `KPI_RST_BYTE)
	else $error("disabled low-level channel flagged");

	// a register write lands on the next edge
	a_enable_write: assert property (
		wr_enable |=> (en_q == $past(rif.wr_data, 1)))
	else $error("enable write not stored");

	// each select register keeps its own written value per channel
	a_select_low: assert property (
		wr_sel_lo |=> (sel_lo_q == $past(rif.wr_data, 1)))
	else $error("low select write not stored");

	// both registers together pick the trigger type of a channel
	a_select_high: assert property (
		wr_sel_hi |=> (sel_hi_q == $past(rif.wr_data, 1)))
	else $error("high select write not stored");

	// the request stays low while the interrupt enable is off
	a_irq_gate: assert property (
		!ctrl_q[`KPI_CTRL_IRQ_EN] |=> !keypad_irq)
	else $error("request while interrupt disabled");

	// no wake request while the cpu runs, while wake is off or with no flag
	a_wake_awake: assert property (
		!cpu_idle && !cpu_power_down |=> !wake_req)
	else $error("wake request while the cpu runs");

	a_wake_gate: assert property (
		!ctrl_q[`KPI_CTRL_WAKE_EN] |=> !wake_req)
	else $error("wake request while wake disabled");

	a_wake_quiet: assert property (
		!any_flag |=> !wake_req)
	else $error("wake request without an enabled flag");
endmodule

//--- kpi_map.svh
// register map, field positions, reset values and codes of the port-zero pin interrupt unit
// assumes inclusion by kpi_pkg and by the unit's modules; definitions only
`ifndef KPI_MAP_SVH
`define KPI_MAP_SVH

`define KPI_AW          12
`define KPI_DW          32
`define KPI_SW          4
`define KPI_IDX_RANGE   9:2
`define KPI_LOW_RANGE   1:0
`define KPI_TOP_RANGE   11:10
`define KPI_LANE0       7:0
`define KPI_LANE0_STB   0
`define KPI_ZERO2       2'b00

`define KPI_IDX_ENABLE  8'he9
`define KPI_IDX_FLAGS   8'hea
`define KPI_IDX_SEL_LO  8'heb
`define KPI_IDX_SEL_HI  8'hec
`define KPI_IDX_CTRL    8'hed
`define KPI_IDX_PINS    8'hee

`define KPI_RST_BYTE    8'h00
`define KPI_RST_CTRL    2'h0
`define KPI_CTRL_PAD    6'h00
`define KPI_WORD_PAD    24'h000000
`define KPI_WORD_ZERO   32'h00000000
`define KPI_PIN_IDLE    8'hff
`define KPI_CTRL_IRQ_EN  0
`define KPI_CTRL_WAKE_EN 1

`define KPI_TRIG_FALL   2'b00
`define KPI_TRIG_RISE   2'b01
`define KPI_TRIG_BOTH   2'b10
`define KPI_TRIG_LOW    2'b11

`define KPI_RESP_OKAY   2'b00
`define KPI_RESP_SLVERR 2'b10

`endif

//--- kpi_pkg.sv
// types and shared decode for the port-zero pin interrupt unit
// assumes kpi_map.svh is reachable by bare name
package kpi_pkg;
`include "kpi_map.svh"

	typedef enum logic [1:0]
	{
		trig_fall = `KPI_TRIG_FALL,
		trig_rise = `KPI_TRIG_RISE,
		trig_both = `KPI_TRIG_BOTH,
		trig_low  = `KPI_TRIG_LOW
	} kpi_trig_t;

	typedef logic [`KPI_AW-1:0] kpi_addr_t;

	function automatic logic [7:0] kpi_reg_idx(input kpi_addr_t a);
		return a[`KPI_IDX_RANGE];
	endfunction

	function automatic logic kpi_mapped(input kpi_addr_t a);
		logic [7:0] i;
		i = kpi_reg_idx(a);
		return (a[`KPI_LOW_RANGE] == `KPI_ZERO2) && (a[`KPI_TOP_RANGE] == `KPI_ZERO2)
			&& (i >= `KPI_IDX_ENABLE) && (i <= `KPI_IDX_PINS);
	endfunction

	// level mode never reports an edge
	function automatic logic kpi_edge_hit(input kpi_trig_t m, input logic rise, input logic fall);
		case (m)
			trig_fall: return fall;
			trig_rise: return rise;
			trig_both: return rise | fall;
			default:   return 1'b0;
		endcase
	endfunction
endpackage

//--- kpi_reg_if.sv
// register access path between the bus slave and the register file
// assumes both ends run on the same clock
interface kpi_reg_if;
	import kpi_pkg::*;
	logic       wr_stb;
	kpi_addr_t  wr_addr;
	logic [7:0] wr_data;
	kpi_addr_t  rd_addr;
	logic [7:0] rd_data;

	modport bus  (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

//--- kpi_pin_sync.sv
// three-stage synchroniser for the eight port-zero pins
// assumes asynchronous pins; a change counts once stages two and three agree
`include "kpi_map.svh"
module kpi_pin_sync
(
	// clock and reset
	input  logic       aclk,
	input  logic       aresetn,
	// pins and settled level
	input  logic [7:0] pin_in,
	output logic [7:0] level_q
);
	logic [7:0] s1_q;
	logic [7:0] s2_q;
	logic [7:0] s3_q;
	logic [7:0] agree;

	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q    <= `KPI_PIN_IDLE;
			s2_q    <= `KPI_PIN_IDLE;
			s3_q    <= `KPI_PIN_IDLE;
			level_q <= `KPI_PIN_IDLE;
		end
		else
		begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end
endmodule

//--- kpi_axil_slave.sv
// axi4-lite slave front end: one write and one read at a time
// assumes a register file on the regs side that answers reads combinationally
`include "kpi_map.svh"
module kpi_axil_slave
	import kpi_pkg::*;
(
	// clock and reset
	input  logic              aclk,
	input  logic              aresetn,
	// write address
	input  kpi_addr_t         s_axi_awaddr,
	input  logic              s_axi_awvalid,
	output logic              s_axi_awready,
	// write data
	input  logic [`KPI_DW-1:0] s_axi_wdata,
	input  logic [`KPI_SW-1:0] s_axi_wstrb,
	input  logic              s_axi_wvalid,
	output logic              s_axi_wready,
	// write response
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  logic              s_axi_bready,
	// read address
	input  kpi_addr_t         s_axi_araddr,
	input  logic              s_axi_arvalid,
	output logic              s_axi_arready,
	// read data
	output logic [`KPI_DW-1:0] s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  logic              s_axi_rready,
	// register side
	kpi_reg_if.bus            rif
);
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q, w_lane_q;
	logic aw_take, w_take, do_wr, ar_take, aw_have_d, w_have_d, bvalid_d, rvalid_d;
	kpi_addr_t          aw_addr_q;
	logic [7:0]         w_byte_q;
	logic [1:0]         bresp_q;
	logic [1:0]         rresp_q;
	logic [`KPI_DW-1:0] rdata_q;

	assign aw_take   = s_axi_awvalid & awready_q;
	assign w_take    = s_axi_wvalid & wready_q;
	assign do_wr     = aw_have_q & w_have_q & ~bvalid_q;
	assign aw_have_d = ~do_wr & (aw_have_q | aw_take);
	assign w_have_d  = ~do_wr & (w_have_q | w_take);
	assign bvalid_d  = do_wr | (bvalid_q & ~s_axi_bready);
	assign ar_take   = s_axi_arvalid & arready_q;
	assign rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready);

	assign rif.wr_stb  = do_wr & w_lane_q & kpi_mapped(aw_addr_q);
	assign rif.wr_addr = aw_addr_q;
	assign rif.wr_data = w_byte_q;
	assign rif.rd_addr = s_axi_araddr;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= ~aw_have_d;
			wready_q  <= ~w_have_d;
			bvalid_q  <= bvalid_d;
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr_q <= '0;
			w_byte_q  <= `KPI_RST_BYTE;
			w_lane_q  <= 1'b0;
			bresp_q   <= `KPI_RESP_OKAY;
			rresp_q   <= `KPI_RESP_OKAY;
			rdata_q   <= `KPI_WORD_ZERO;
		end
		else
		begin
			if (aw_take)
				aw_addr_q <= s_axi_awaddr;
			if (w_take)
			begin
				w_byte_q <= s_axi_wdata[`KPI_LANE0];
				w_lane_q <= s_axi_wstrb[`KPI_LANE0_STB];
			end
			if (do_wr)
				bresp_q <= kpi_mapped(aw_addr_q) ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
			if (ar_take)
			begin
				rdata_q <= kpi_mapped(s_axi_araddr) ? {`KPI_WORD_PAD, rif.rd_data} : `KPI_WORD_ZERO;
				rresp_q <= kpi_mapped(s_axi_araddr) ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
			end
		end
	end
endmodule

//--- kpi_keypad_model.sv
// keypad model: one switch per port-zero pin, pulled up, a pressed key shorts its pin to ground
// assumes the bench presses and releases keys off the sampling edge of aclk
module kpi_keypad_model
(
	// key state from the bench
	input  logic [7:0] keys_down,
	// pins towards the unit
	output logic [7:0] port_zero
);
	timeunit 1ns;
	timeprecision 100ps;

	// released keys read high, so pins sit high before any falling-edge wake-up
	// the service side finds the pressed key from these levels
	assign port_zero = ~keys_down;
endmodule

//--- test_keypad_pin_interrupt.sv
// self-checking bench for the port-zero pin interrupt unit, random pin traffic with fixed seed
// assumes kpi_pkg, kpi_map.svh, the unit and kpi_keypad_model are compiled first
`include "kpi_map.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %0t mismatch got %h expected %h", $time, (got), (exp)); end end
module test_keypad_pin_interrupt
	import kpi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int        irq_lat = 7;
	localparam kpi_addr_t a_en    = kpi_addr_t'({`KPI_IDX_ENABLE, 2'b00});
	localparam kpi_addr_t a_fl    = kpi_addr_t'({`KPI_IDX_FLAGS, 2'b00});
	localparam kpi_addr_t a_lo    = kpi_addr_t'({`KPI_IDX_SEL_LO, 2'b00});
	localparam kpi_addr_t a_hi    = kpi_addr_t'({`KPI_IDX_SEL_HI, 2'b00});
	localparam kpi_addr_t a_ctl   = kpi_addr_t'({`KPI_IDX_CTRL, 2'b00});
	localparam kpi_addr_t a_pin   = kpi_addr_t'({`KPI_IDX_PINS, 2'b00});

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	kpi_addr_t   s_axi_awaddr = '0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b1;
	kpi_addr_t   s_axi_araddr = '0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b1;
	logic [7:0]  keys_down = 8'h00;
	logic [7:0]  port_zero;
	logic        cpu_idle = 1'b0;
	logic        cpu_power_down = 1'b0;
	logic        keypad_irq;
	logic        wake_req;
	int          failures = 0;
	int          num_checks = 0;
	int          seed = 47859;
	int          n;
	logic [1:0]  rs;
	logic [7:0]  en, lo, hi, pins, nxt, expf;

	always #2.5 aclk = ~aclk;

	kpi_keypad_model u_kpi_keypad_model (.keys_down(keys_down), .port_zero(port_zero));

	kpi_keypad_pin_interrupt u_kpi_keypad_pin_interrupt
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_zero(port_zero),
		.cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down), .keypad_irq(keypad_irq), .wake_req(wake_req)
	);

	// expected flags after the pins move from po to pn; low-level channels follow the inverted pin
	function automatic logic [7:0] exp_flags(input logic [7:0] f, po, pn, e, l, h);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
		begin
			case ({h[i], l[i]})
				2'b00:   r[i] = f[i] | (po[i] & ~pn[i]);
				2'b01:   r[i] = f[i] | (~po[i] & pn[i]);
				2'b10:   r[i] = f[i] | (po[i] ^ pn[i]);
				default: r[i] = ~pn[i];
			endcase
			r[i] = r[i] & e[i];
		end
		return r;
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge aclk);
	endtask

	task automatic wr(input kpi_addr_t a, input logic [7:0] d, input logic [3:0] st, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		int   k;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		k = 0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_wstrb   <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (!(aw_ok && w_ok) && k < 50)
		begin
			@(posedge aclk);
			k++;
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_bvalid !== 1'b1 && k < 50);
		r = s_axi_bresp;
		if (k >= 50)
		begin
			failures++;
			$display("[FAIL] %0t write response timeout", $time);
		end
	endtask

	task automatic wr_ok(input kpi_addr_t a, input logic [7:0] d);
		wr(a, d, 4'hf, rs);
		`CHK(rs, `KPI_RESP_OKAY)
	endtask

	task automatic chk_rd(input kpi_addr_t a, input logic [7:0] e, input logic [1:0] er);
		int k;
		k = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_arready !== 1'b1 && k < 50);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_rvalid !== 1'b1 && k < 50);
		if (k >= 50)
		begin
			failures++;
			$display("[FAIL] %0t read response timeout", $time);
		end
		`CHK(s_axi_rdata, {24'h000000, e})
		`CHK(s_axi_rresp, er)
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge aclk);
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report;
	end

	initial
	begin
		tick(16);
		aresetn <= 1'b1;
		tick(2);
		chk_rd(a_en, `KPI_RST_BYTE, `KPI_RESP_OKAY);
		chk_rd(a_fl, `KPI_RST_BYTE, `KPI_RESP_OKAY);
		chk_rd(a_lo, `KPI_RST_BYTE, `KPI_RESP_OKAY);
		chk_rd(a_hi, `KPI_RST_BYTE, `KPI_RESP_OKAY);
		chk_rd(a_pin, `KPI_PIN_IDLE, `KPI_RESP_OKAY);
		chk_rd(12'h3bc, 8'h00, `KPI_RESP_SLVERR);
		chk_rd(12'h3a5, 8'h00, `KPI_RESP_SLVERR);
		wr(12'h000, 8'hff, 4'hf, rs);
		`CHK(rs, `KPI_RESP_SLVERR)
		wr(a_en, 8'h5a, 4'he, rs);
		chk_rd(a_en, 8'h00, `KPI_RESP_OKAY);
		// falling edges on channels 0 and 1 with only channel 0 enabled, latency to the combined request
		wr_ok(a_en, 8'h01);
		wr_ok(a_ctl, 8'h01);
		keys_down <= 8'h03;
		n = 0;
		do
		begin
			@(posedge aclk);
			#1;
			n++;
		end
		while (keypad_irq !== 1'b1 && n < 40);
		`CHK(n, irq_lat)
		chk_rd(a_fl, 8'h01, `KPI_RESP_OKAY);
		keys_down <= 8'h00;
		tick(12);
		chk_rd(a_fl, 8'h01, `KPI_RESP_OKAY);
		wr_ok(a_ctl, 8'h02);
		tick(3);
		`CHK(keypad_irq, 1'b0)
		`CHK(wake_req, 1'b0)
		cpu_idle <= 1'b1;
		tick(3);
		`CHK(wake_req, 1'b1)
		cpu_idle <= 1'b0;
		cpu_power_down <= 1'b1;
		tick(3);
		`CHK(wake_req, 1'b1)
		wr_ok(a_fl, 8'h00);
		tick(3);
		`CHK(wake_req, 1'b0)
		// power-down entered with the pin high, then a falling edge wakes the cpu
		keys_down <= 8'h01;
		tick(12);
		`CHK(wake_req, 1'b1)
		keys_down <= 8'h00;
		wr_ok(a_fl, 8'h00);
		cpu_power_down <= 1'b0;
		// rounds of random pin traffic; round 0 sets every trigger type, channel 7 disabled
		for (int rnd = 0; rnd < 4; rnd++)
		begin
			en = (rnd == 0) ? 8'h7f : 8'($random(seed));
			lo = (rnd == 0) ? 8'haa : 8'($random(seed));
			hi = (rnd == 0) ? 8'hcc : 8'($random(seed));
			wr_ok(a_en, en);
			wr_ok(a_lo, lo);
			wr_ok(a_hi, hi);
			wr_ok(a_ctl, 8'h01);
			wr_ok(a_fl, 8'h00);
			chk_rd(a_lo, lo, `KPI_RESP_OKAY);
			chk_rd(a_hi, hi, `KPI_RESP_OKAY);
			pins = 8'hff;
			expf = 8'h00;
			for (int s = 0; s < 10; s++)
			begin
				nxt = (s == 0) ? 8'h00 : 8'($random(seed));
				keys_down <= ~nxt;
				tick(12);
				expf = exp_flags(expf, pins, nxt, en, lo, hi);
				pins = nxt;
				chk_rd(a_fl, expf, `KPI_RESP_OKAY);
				`CHK(keypad_irq, |expf)
				chk_rd(a_pin, pins, `KPI_RESP_OKAY);
				if (s % 3 == 2)
				begin
					wr_ok(a_fl, 8'h00);
					expf = exp_flags(8'h00, pins, pins, en, lo, hi);
					chk_rd(a_fl, expf, `KPI_RESP_OKAY);
				end
			end
			keys_down <= 8'h00;
			tick(12);
		end
		final_report;
	end
endmodule
